// ---- rtl/pfs_pkg.sv ----
package pfs_pkg;
  localparam logic [11:0] PFS_FUNC_OFS  = 12'h000;
  localparam logic [11:0] PFS_DIR_OFS   = 12'h004;
  localparam logic [11:0] PFS_LATCH_OFS = 12'h008;
  localparam logic [11:0] PFS_PIN_OFS   = 12'h00C;
  localparam logic [7:0]  PFS_FUNC_RST  = 8'h00;
  localparam logic [7:0]  PFS_DIR_RST   = 8'h00;
  localparam logic [7:0]  PFS_LATCH_RST = 8'h00;
  localparam logic [7:0]  PFS_DIR_READ  = 8'hFF;
  localparam logic [7:0]  PFS_SYNC_RST  = 8'hFF;
  localparam int          PFS_STROBE_BIT = 6;
  localparam int          PFS_CH2_SO_BIT = 5;
  localparam int          PFS_CH2_SI_BIT = 4;
  localparam int          PFS_CH2_CK_BIT = 3;
  localparam int          PFS_CH1_SO_BIT = 2;
  localparam int          PFS_CH1_SI_BIT = 1;
  localparam int          PFS_CH1_CK_BIT = 0;
  localparam int          PFS_CS_BIT     = 7;
endpackage : pfs_pkg

// ---- rtl/pfs_port_mux.sv ----
// How it works
// - Bit 6 set: pin 6 drives strobe always
// - Bit 5 set: pin 5 drives channel 2 data
// - Bit 4 set: pin 4 is channel 2 input
// - Bit 3 set: pin 3 is channel 2 clock
// - Bit 2 set: pin 2 drives channel 1 data
// - Bit 1 set: pin 1 is channel 1 input
// - Bit 0 set: pin 0 is channel 1 clock
// - Bit 7 set: pin 7 is chip-select input
// - Pin 5 direction ignored in serial mode
// - Direction one drives latch, zero is input
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/10ps
`default_nettype none
module pfs_port_mux (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  pin_in,
  output logic      [7:0]  pin_out,
  output logic      [7:0]  pin_oe,
  input  wire logic        strobe_out,
  input  wire logic        ch1_so,
  input  wire logic        ch2_so,
  input  wire logic        ch1_sck_out,
  input  wire logic        ch1_sck_oe,
  input  wire logic        ch2_sck_out,
  input  wire logic        ch2_sck_oe,
  output logic             ch1_si,
  output logic             ch2_si,
  output logic             ch1_sck_in,
  output logic             ch2_sck_in,
  output logic             cs_n
);
  logic [7:0]  func_reg,  func_next;
  logic [7:0]  dir_reg,   dir_next;
  logic [7:0]  latch_reg, latch_next;
  logic [7:0]  s1_reg, s2_reg, s3_reg, filt_reg, filt_next;
  logic [7:0]  out_reg,   out_next;
  logic [7:0]  oe_reg,    oe_next;
  logic [4:0]  in_reg,    in_next;
  logic [31:0] rdata_reg, rdata_next;
  logic        err_reg,   err_next;
  logic [7:0]  alt_out, alt_oe, pin_state;
  logic        wr_en, setup, hit;

  assign pready  = 1'b1;
  assign prdata  = rdata_reg;
  assign pslverr = err_reg;
  assign pin_out = out_reg;
  assign pin_oe  = oe_reg;
  assign {cs_n, ch2_si, ch2_sck_in, ch1_si, ch1_sck_in} = in_reg;

  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite;
  assign hit   = (paddr == pfs_pkg::PFS_FUNC_OFS) || (paddr == pfs_pkg::PFS_DIR_OFS) ||
                 (paddr == pfs_pkg::PFS_LATCH_OFS) || (paddr == pfs_pkg::PFS_PIN_OFS);

  // Register writes
  always_comb begin
    func_next  = func_reg;
    dir_next   = dir_reg;
    latch_next = latch_reg;
    if (wr_en) begin
      case (paddr)
        pfs_pkg::PFS_FUNC_OFS:  func_next  = pwdata[7:0];
        pfs_pkg::PFS_DIR_OFS:   dir_next   = pwdata[7:0];
        pfs_pkg::PFS_LATCH_OFS: latch_next = pwdata[7:0];
        default: ;
      endcase
    end
  end

  // Read data and error captured in setup, shown in access
  always_comb begin
    rdata_next = rdata_reg;
    err_next   = err_reg;
    if (setup) begin
      err_next   = !hit;
      rdata_next = 32'h0000_0000;
      if (!pwrite) begin
        case (paddr)
          pfs_pkg::PFS_FUNC_OFS:  rdata_next[7:0] = func_reg;
          pfs_pkg::PFS_DIR_OFS:   rdata_next[7:0] = pfs_pkg::PFS_DIR_READ;
          pfs_pkg::PFS_LATCH_OFS: rdata_next[7:0] = latch_reg;
          pfs_pkg::PFS_PIN_OFS:   rdata_next[7:0] = pin_state;
          default: ;
        endcase
      end
    end
  end

  assign alt_out = {1'b0, strobe_out, ch2_so, 1'b0, ch2_sck_out, ch1_so, 1'b0, ch1_sck_out};
  assign alt_oe  = {1'b0, 1'b1, 1'b1, 1'b0, ch2_sck_oe, 1'b1, 1'b0, ch1_sck_oe};

  // Per-pin mux and input filter
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_pin
      always_comb begin
        out_next[i]  = func_reg[i] ? alt_out[i] : latch_reg[i];
        oe_next[i]   = func_reg[i] ? alt_oe[i]  : dir_reg[i];
        filt_next[i] = (s2_reg[i] == s3_reg[i]) ? s2_reg[i] : filt_reg[i];
        pin_state[i] = (dir_reg[i] && !func_reg[i]) ? latch_reg[i] : filt_reg[i];
      end
    end
  endgenerate

  // Alternate inputs idle high when the pin is not assigned
  always_comb begin
    in_next[4] = func_reg[pfs_pkg::PFS_CS_BIT]     ? filt_reg[pfs_pkg::PFS_CS_BIT]     : 1'b1;
    in_next[3] = func_reg[pfs_pkg::PFS_CH2_SI_BIT] ? filt_reg[pfs_pkg::PFS_CH2_SI_BIT] : 1'b1;
    in_next[2] = func_reg[pfs_pkg::PFS_CH2_CK_BIT] ? filt_reg[pfs_pkg::PFS_CH2_CK_BIT] : 1'b1;
    in_next[1] = func_reg[pfs_pkg::PFS_CH1_SI_BIT] ? filt_reg[pfs_pkg::PFS_CH1_SI_BIT] : 1'b1;
    in_next[0] = func_reg[pfs_pkg::PFS_CH1_CK_BIT] ? filt_reg[pfs_pkg::PFS_CH1_CK_BIT] : 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      func_reg  <= pfs_pkg::PFS_FUNC_RST;
      dir_reg   <= pfs_pkg::PFS_DIR_RST;
      latch_reg <= pfs_pkg::PFS_LATCH_RST;
      s1_reg    <= pfs_pkg::PFS_SYNC_RST;
      s2_reg    <= pfs_pkg::PFS_SYNC_RST;
      s3_reg    <= pfs_pkg::PFS_SYNC_RST;
      filt_reg  <= pfs_pkg::PFS_SYNC_RST;
      out_reg   <= 8'h00;
      oe_reg    <= 8'h00;
      in_reg    <= 5'h1F;
      rdata_reg <= 32'h0000_0000;
      err_reg   <= 1'b0;
    end else begin
      func_reg  <= func_next;
      dir_reg   <= dir_next;
      latch_reg <= latch_next;
      s1_reg    <= pin_in;
      s2_reg    <= s1_reg;
      s3_reg    <= s2_reg;
      filt_reg  <= filt_next;
      out_reg   <= out_next;
      oe_reg    <= oe_next;
      in_reg    <= in_next;
      rdata_reg <= rdata_next;
      err_reg   <= err_next;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  strobe_drive_a: assert property (func_reg[6] |=> pin_oe[6] && pin_out[6] == $past(strobe_out))
    else $error("strobe not driven on pin 6");
  ch2_out_a: assert property (func_reg[5] |=> pin_oe[5] && pin_out[5] == $past(ch2_so))
    else $error("channel 2 data not driven on pin 5");
  ch2_in_a: assert property (func_reg[4] |=> !pin_oe[4] && ch2_si == $past(filt_reg[4]))
    else $error("pin 4 not a channel 2 input");
  ch2_clk_a: assert property (func_reg[3] |=> pin_oe[3] == $past(ch2_sck_oe)
                              && pin_out[3] == $past(ch2_sck_out))
    else $error("pin 3 clock routing wrong");
  ch1_out_a: assert property (func_reg[2] |=> pin_oe[2] && pin_out[2] == $past(ch1_so))
    else $error("channel 1 data not driven on pin 2");
  ch1_in_a: assert property (func_reg[1] |=> !pin_oe[1] && ch1_si == $past(filt_reg[1]))
    else $error("pin 1 not a channel 1 input");
  ch1_clk_a: assert property (func_reg[0] |=> pin_oe[0] == $past(ch1_sck_oe)
                              && pin_out[0] == $past(ch1_sck_out))
    else $error("pin 0 clock routing wrong");
  cs_input_a: assert property (func_reg[7] |=> !pin_oe[7] && cs_n == $past(filt_reg[7]))
    else $error("pin 7 not chip-select input");
  pin5_dir_a: assert property (!func_reg[5] |=> pin_oe[5] == $past(dir_reg[5]))
    else $error("pin 5 direction not honoured");
  gpio_drive_a: assert property (func_next == func_reg && dir_next == dir_reg &&
                                 latch_next == latch_reg |=>
                                 (pin_oe & ~func_reg) == (dir_reg & ~func_reg) &&
                                 (pin_out & ~func_reg) == (latch_reg & ~func_reg))
    else $error("general pin drive mismatch");
  alt_dir_a: assert property (func_next == func_reg |=>
                              (pin_oe & func_reg) == ($past(alt_oe) & func_reg))
    else $error("alternate function direction wrong");
  func_write_a: assert property (wr_en && paddr == pfs_pkg::PFS_FUNC_OFS |=>
                                 func_reg == $past(pwdata[7:0]))
    else $error("function select write lost");
  ch2_clk_in_a: assert property (func_reg[3] |=> ch2_sck_in == $past(filt_reg[3]))
    else $error("pin 3 level not routed to channel 2 clock");
  ch1_clk_in_a: assert property (func_reg[0] |=> ch1_sck_in == $past(filt_reg[0]))
    else $error("pin 0 level not routed to channel 1 clock");
  cs_idle_a: assert property (!func_reg[7] |=> cs_n)
    else $error("chip-select not idle in general mode");
  si_idle_a: assert property (!func_reg[4] && !func_reg[1] |=> ch2_si && ch1_si)
    else $error("serial input not idle in general mode");
  sck_idle_a: assert property (!func_reg[3] && !func_reg[0] |=> ch2_sck_in && ch1_sck_in)
    else $error("serial clock input not idle in general mode");

  // Bus side checks
  bad_addr_a: assert property (setup && !hit |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not flagged");
  dir_read_a: assert property (setup && !pwrite && paddr == pfs_pkg::PFS_DIR_OFS |=>
                               prdata[7:0] == pfs_pkg::PFS_DIR_READ)
    else $error("direction register read not all ones");
  pin_read_a: assert property (setup && !pwrite && paddr == pfs_pkg::PFS_PIN_OFS |=>
                               prdata[7:0] == $past(pin_state))
    else $error("pin state read wrong");
  func_read_a: assert property (setup && !pwrite && paddr == pfs_pkg::PFS_FUNC_OFS |=>
                                prdata[7:0] == $past(func_reg))
    else $error("function select read wrong");
  latch_write_a: assert property (wr_en && paddr == pfs_pkg::PFS_LATCH_OFS |=>
                                  latch_reg == $past(pwdata[7:0]))
    else $error("output latch write lost");
  dir_write_a: assert property (wr_en && paddr == pfs_pkg::PFS_DIR_OFS |=>
                                dir_reg == $past(pwdata[7:0]))
    else $error("direction write lost");

  // Main scenarios
  strobe_mode_c: cover property (func_reg[6] ##1 pin_oe[6] && pin_out[6]);
  gpio_out_c:    cover property (!func_reg[0] && dir_reg[0] ##1 pin_oe[0]);
  bad_addr_c:    cover property (psel && penable && pslverr);
  ch2_in_c:      cover property (func_reg[4] ##1 !pin_oe[4] && !ch2_si);
  clock_in_c:    cover property (func_reg[0] && !ch1_sck_oe ##1 !pin_oe[0]);
endmodule : pfs_port_mux
`default_nettype wire

// ---- testbench/pfs_far_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module pfs_far_model (
  input  wire logic [14:0] ext,
  input  wire logic [7:0]  pin_out,
  input  wire logic [7:0]  pin_oe,
  output logic      [7:0]  pin_in,
  output logic      [6:0]  chan
);
  // Pad sees the driven value, else the outside level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext[7:0]);
  assign chan   = ext[14:8];
endmodule : pfs_far_model
`default_nettype wire

// ---- testbench/port3_pin_function_select_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
module port3_pin_function_select_bench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, chk;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0]  pin_in, pin_out, pin_oe, f, d, l, oe_e, out_e, pv, st, ci;
  logic [6:0]  chan;
  logic [14:0] ext;
  logic        ch1_si, ch2_si, ch1_sck_in, ch2_sck_in, cs_n;
  logic [32:0] rq[$];
  logic [32:0] pq[$];
  int          n_fail, checked;
  pfs_port_mux i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .strobe_out(chan[0]), .ch1_so(chan[1]), .ch2_so(chan[2]), .ch1_sck_out(chan[3]),
    .ch1_sck_oe(chan[4]), .ch2_sck_out(chan[5]), .ch2_sck_oe(chan[6]), .ch1_si(ch1_si),
    .ch2_si(ch2_si), .ch1_sck_in(ch1_sck_in), .ch2_sck_in(ch2_sck_in), .cs_n(cs_n));
  pfs_far_model i_far (.ext(ext), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in),
    .chan(chan));
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task end_of_test();
    $display("checks %0d failures %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  task cmp(input string nm, input logic [32:0] e, input logic [32:0] s);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask : cmp
  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 8; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 8) begin
      n_fail++;
      end_of_test();
    end
  endtask : apb
  task rd(input logic [11:0] a, input logic [32:0] e);
    rq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && rq.size() > 0)
      cmp("prdata", rq.pop_front(), {pslverr, prdata});
    if (chk && pq.size() > 0)
      cmp("pins", pq.pop_front(), {12'h0, pin_oe, pin_out & pin_oe, cs_n, ch2_sck_in, ch2_si,
        ch1_sck_in, ch1_si});
  end
  initial begin
    #2000000;
    n_fail++;
    end_of_test();
  end
  initial begin
    void'($urandom(32'h7875117B));
    {presetn, psel, penable, pwrite, paddr, pwdata, ext, chk} = '0;
    n_fail = 0;
    checked = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(pfs_pkg::PFS_FUNC_OFS, 33'h0);
    rd(pfs_pkg::PFS_DIR_OFS, 33'h0FF);
    rd(12'h010, 33'h100000000);
    for (int i = 0; i < 40; i++) begin
      f = (i == 0) ? 8'hFF : ((i == 1) ? 8'h00 : 8'($urandom));
      d = 8'($urandom);
      l = 8'($urandom);
      ext <= 15'($urandom);
      apb(1'b1, pfs_pkg::PFS_FUNC_OFS, {24'h0, f});
      apb(1'b1, pfs_pkg::PFS_DIR_OFS, {24'h0, d});
      apb(1'b1, pfs_pkg::PFS_LATCH_OFS, {24'h0, l});
      apb(1'b1, 12'h010, $urandom);
      repeat (8) @(posedge pclk);
      oe_e = (~f & d) | (f & {1'b0, 2'b11, 1'b0, ext[14], 1'b1, 1'b0, ext[12]});
      out_e = (~f & l) | (f & {1'b0, ext[8], ext[10], 1'b0, ext[13], ext[9], 1'b0, ext[11]});
      pv = (oe_e & out_e) | (~oe_e & ext[7:0]);
      ci = pv | ~f;
      st = (d & ~f & l) | (~(d & ~f) & pv);
      pq.push_back({12'h0, oe_e, out_e & oe_e, ci[7], ci[3], ci[4], ci[0], ci[1]});
      chk <= 1'b1;
      @(posedge pclk);
      chk <= 1'b0;
      rd(pfs_pkg::PFS_FUNC_OFS, {25'h0, f});
      rd(pfs_pkg::PFS_PIN_OFS, {25'h0, st});
      rd(pfs_pkg::PFS_LATCH_OFS, {25'h0, l});
    end
    end_of_test();
  end
endmodule : port3_pin_function_select_bench
`default_nettype wire
